// ===== hw/trip_flag_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - a clear with overflow low reads back the trip flag as low
// - a decoded set strobe forces the trip flag high
// - after a clear, a gated clock pulse sets the flag again
// - overflow rising while run set and flag clear sets the flag
// - master enable line driven high or low as configured
// - trip enable line driven high or low as configured
// - trip line driven high or low as configured
// - default mode leaves all three bus lines released high
module trip_flag_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter overflow pin
  input wire logic overflow_pin,
  // inter_module_bus open-drain lines: in, out, enable (low drives)
  input wire logic bus_master_enable_line_in,
  output logic bus_master_enable_line_out,
  output logic bus_master_enable_line_oe_n,
  input wire logic bus_trip_enable_line_in,
  output logic bus_trip_enable_line_out,
  output logic bus_trip_enable_line_oe_n,
  input wire logic bus_trip_line_in,
  output logic bus_trip_line_out,
  output logic bus_trip_line_oe_n,
  // interrupt and flag
  output logic irq,
  output logic trip_flag
);
  // ===========================================================
  // synchronised inputs
  logic ovf_s;
  logic me_s;
  logic te_s;
  logic tr_s;

  pin_sync u_ovf (.clk(clk), .rst(rst), .pin(overflow_pin), .level(ovf_s));
  pin_sync u_me (.clk(clk), .rst(rst), .pin(bus_master_enable_line_in),
    .level(me_s));
  pin_sync u_te (.clk(clk), .rst(rst), .pin(bus_trip_enable_line_in),
    .level(te_s));
  pin_sync u_tr (.clk(clk), .rst(rst), .pin(bus_trip_line_in),
    .level(tr_s));

  // ===========================================================
  // apb decode; zero wait states
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = (paddr == trip_pkg::ctrl_off) ||
    (paddr == trip_pkg::status_off) || (paddr == trip_pkg::strobe_off) ||
    (paddr == trip_pkg::irq_stat_off) || (paddr == trip_pkg::irq_mask_off);

  // ===========================================================
  // control registers
  logic [5:0] ctrl_r;
  logic [5:0] ctrl_nxt;
  logic [0:0] mask_r;
  logic [0:0] mask_nxt;
  logic set_stb_r;
  logic set_stb_nxt;
  logic clr_stb_r;
  logic clr_stb_nxt;
  logic gclk_stb_r;
  logic gclk_stb_nxt;

  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    set_stb_nxt = 1'b0;
    clr_stb_nxt = 1'b0;
    gclk_stb_nxt = 1'b0;
    if (wr_acc && paddr == trip_pkg::ctrl_off) begin
      ctrl_nxt = pwdata[5:0];
    end
    if (wr_acc && paddr == trip_pkg::irq_mask_off) begin
      mask_nxt = pwdata[0:0];
    end
    if (wr_acc && paddr == trip_pkg::strobe_off) begin
      set_stb_nxt = pwdata[trip_pkg::stb_set_bit];
      clr_stb_nxt = pwdata[trip_pkg::stb_clr_bit];
      gclk_stb_nxt = pwdata[trip_pkg::stb_clk_bit] &&
        ctrl_r[trip_pkg::ctl_gate_en_bit];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= trip_pkg::ctrl_rst;
      mask_r <= trip_pkg::irq_mask_rst;
      set_stb_r <= 1'b0;
      clr_stb_r <= 1'b0;
      gclk_stb_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      set_stb_r <= set_stb_nxt;
      clr_stb_r <= clr_stb_nxt;
      gclk_stb_r <= gclk_stb_nxt;
    end
  end

  // ===========================================================
  // trip flag state machine
  trip_pkg::flag_state_t st_r;
  trip_pkg::flag_state_t st_nxt;
  logic ovf_d_r;
  logic ovf_rise;
  logic run;
  assign run = ctrl_r[trip_pkg::ctl_run_bit];
  assign ovf_rise = ovf_s && !ovf_d_r;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      trip_pkg::fl_clear: begin
        if (run) begin
          st_nxt = trip_pkg::fl_armed;
        end
        if (set_stb_r || gclk_stb_r) begin
          st_nxt = trip_pkg::fl_tripped;
        end
      end
      trip_pkg::fl_armed: begin
        if (!run) begin
          st_nxt = trip_pkg::fl_clear;
        end
        if (run && ovf_rise) begin
          st_nxt = trip_pkg::fl_tripped;
        end
        if (set_stb_r || gclk_stb_r) begin
          st_nxt = trip_pkg::fl_tripped;
        end
      end
      trip_pkg::fl_tripped: begin
        st_nxt = trip_pkg::fl_tripped;
      end
      default: begin
        st_nxt = trip_pkg::fl_clear;
      end
    endcase
    if (clr_stb_r) begin
      st_nxt = trip_pkg::fl_clear;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= trip_pkg::fl_clear;
      ovf_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ovf_d_r <= ovf_s;
    end
  end

  // ===========================================================
  // interrupt: sticky on flag rising, cleared by interrupt status read
  logic flag_now;
  logic flag_rise;
  logic [0:0] ist_r;
  logic [0:0] ist_nxt;
  logic irq_r;
  logic irq_nxt;
  logic trip_r;
  assign flag_now = (st_nxt == trip_pkg::fl_tripped);
  assign flag_rise = flag_now && !trip_r;

  always_comb begin
    ist_nxt = ist_r;
    if (rd_acc && paddr == trip_pkg::irq_stat_off) begin
      ist_nxt = 1'h0;
    end
    // set beats the read clear
    if (flag_rise) begin
      ist_nxt = 1'h1;
    end
    irq_nxt = |(ist_nxt & mask_nxt);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_r <= 1'h0;
      irq_r <= 1'b0;
      trip_r <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      irq_r <= irq_nxt;
      trip_r <= flag_now;
    end
  end

  // ===========================================================
  // module bus line drivers; open drain, so high means released
  logic me_out_r;
  logic te_out_r;
  logic tr_out_r;
  logic me_oe_n_r;
  logic te_oe_n_r;
  logic tr_oe_n_r;
  logic me_oe_n_nxt;
  logic te_oe_n_nxt;
  logic tr_oe_n_nxt;
  logic drive;
  assign drive = ctrl_nxt[trip_pkg::ctl_bus_drive_bit];

  always_comb begin
    // default mode releases all lines high
    me_oe_n_nxt = 1'b1;
    te_oe_n_nxt = 1'b1;
    tr_oe_n_nxt = 1'b1;
    if (drive) begin
      me_oe_n_nxt = ctrl_nxt[trip_pkg::ctl_me_bit];
      te_oe_n_nxt = ctrl_nxt[trip_pkg::ctl_te_bit];
      tr_oe_n_nxt = ctrl_nxt[trip_pkg::ctl_tr_bit];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      me_oe_n_r <= 1'b1;
      te_oe_n_r <= 1'b1;
      tr_oe_n_r <= 1'b1;
      me_out_r <= 1'b0;
      te_out_r <= 1'b0;
      tr_out_r <= 1'b0;
    end else begin
      me_oe_n_r <= me_oe_n_nxt;
      te_oe_n_r <= te_oe_n_nxt;
      tr_oe_n_r <= tr_oe_n_nxt;
      me_out_r <= 1'b0;
      te_out_r <= 1'b0;
      tr_out_r <= 1'b0;
    end
  end

  // ===========================================================
  // read data, registered in the setup phase for zero wait
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic err_r;
  logic err_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (psel && !penable) begin
      err_nxt = !mapped;
      case (paddr)
        trip_pkg::ctrl_off: rdata_nxt = {26'h0, ctrl_r};
        trip_pkg::status_off: rdata_nxt = {27'h0, tr_s, te_s, me_s,
          ovf_s, trip_r};
        trip_pkg::irq_stat_off: rdata_nxt = {31'h0, ist_r};
        trip_pkg::irq_mask_off: rdata_nxt = {31'h0, mask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  assign prdata = rdata_r;
  assign pslverr = err_r;
  assign pready = 1'b1;
  assign irq = irq_r;
  assign trip_flag = trip_r;
  assign bus_master_enable_line_out = me_out_r;
  assign bus_trip_enable_line_out = te_out_r;
  assign bus_trip_line_out = tr_out_r;
  assign bus_master_enable_line_oe_n = me_oe_n_r;
  assign bus_trip_enable_line_oe_n = te_oe_n_r;
  assign bus_trip_line_oe_n = tr_oe_n_r;

  // ===========================================================
  // checks
  sequence clr_pulse;
    clr_stb_r;
  endsequence

  a_clear_reads_low: assert property (@(posedge clk) disable iff (rst)
    clr_pulse |=> !trip_r) else $error("trip flag not low after clear");
  a_set_forces_high: assert property (@(posedge clk) disable iff (rst)
    (set_stb_r && !clr_stb_r) |=> trip_r) else $error("set missed");
  a_gate_clock_sets: assert property (@(posedge clk) disable iff (rst)
    (gclk_stb_r && !clr_stb_r) |=> trip_r) else $error("gate clk missed");
  a_ovf_edge_trips: assert property (@(posedge clk) disable iff (rst)
    (st_r == trip_pkg::fl_armed && run && ovf_rise && !clr_stb_r) |=>
    trip_r) else $error("overflow edge missed");
  a_me_follows_cfg: assert property (@(posedge clk) disable iff (rst)
    ctrl_r[trip_pkg::ctl_bus_drive_bit] |-> me_oe_n_r ==
    ctrl_r[trip_pkg::ctl_me_bit]) else $error("master enable wrong");
  a_te_follows_cfg: assert property (@(posedge clk) disable iff (rst)
    ctrl_r[trip_pkg::ctl_bus_drive_bit] |-> te_oe_n_r ==
    ctrl_r[trip_pkg::ctl_te_bit]) else $error("trip enable wrong");
  a_tr_follows_cfg: assert property (@(posedge clk) disable iff (rst)
    ctrl_r[trip_pkg::ctl_bus_drive_bit] |-> tr_oe_n_r ==
    ctrl_r[trip_pkg::ctl_tr_bit]) else $error("trip line wrong");
  a_default_release: assert property (@(posedge clk) disable iff (rst)
    !ctrl_r[trip_pkg::ctl_bus_drive_bit] |-> (me_oe_n_r && te_oe_n_r &&
    tr_oe_n_r)) else $error("line driven in default mode");
  a_strobe_single: assert property (@(posedge clk) disable iff (rst)
    clr_stb_r |=> !clr_stb_r) else $error("strobe longer than a cycle");
endmodule : trip_flag_ctrl

// ===== hw/trip_pkg.sv
package trip_pkg;
  // ===========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] status_off = 12'h004;
  localparam logic [11:0] strobe_off = 12'h008;
  localparam logic [11:0] irq_stat_off = 12'h00c;
  localparam logic [11:0] irq_mask_off = 12'h010;
  // ===========================================================
  // control register fields
  localparam int ctl_run_bit = 0;
  localparam int ctl_gate_en_bit = 1;
  localparam int ctl_bus_drive_bit = 2;
  localparam int ctl_me_bit = 3;
  localparam int ctl_te_bit = 4;
  localparam int ctl_tr_bit = 5;
  localparam int ctl_width = 6;
  // strobe register fields (write one to pulse)
  localparam int stb_set_bit = 0;
  localparam int stb_clr_bit = 1;
  localparam int stb_clk_bit = 2;
  // status register fields
  localparam int st_trip_bit = 0;
  localparam int st_ovf_bit = 1;
  // interrupt status fields
  localparam int irq_trip_bit = 0;
  localparam int irq_width = 1;
  // ===========================================================
  // reset values
  localparam logic [5:0] ctrl_rst = 6'h00;
  localparam logic [0:0] irq_mask_rst = 1'h0;
  // ===========================================================
  // flag update states
  typedef enum logic [2:0] {
    fl_clear = 3'b001,
    fl_armed = 3'b010,
    fl_tripped = 3'b100
  } flag_state_t;
endpackage : trip_pkg

// ===== hw/pin_sync.sv
`timescale 1ns/1ps
// ===========================================================
// three-stage synchroniser; the output changes once stages two
// and three agree, which also filters single-cycle glitches
module pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and clean level
  input wire logic pin,
  output logic level
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic level_r;
  logic level_nxt;

  always_comb begin
    sh_nxt = {sh_r[1:0], pin};
    level_nxt = level_r;
    if (sh_r[1] == sh_r[2]) begin
      level_nxt = sh_r[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_r <= 3'h0;
      level_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule : pin_sync

// ===== verif/imb_partner.sv
`timescale 1ns/1ps
// ===========================================================
// other modules on the inter_module_bus: pull-ups plus sampling
module imb_partner (
  // driver side of each open-drain line
  input wire logic me_out,
  input wire logic me_oe_n,
  input wire logic te_out,
  input wire logic te_oe_n,
  input wire logic tr_out,
  input wire logic tr_oe_n,
  // levels seen by every module on the bus
  output logic me_line,
  output logic te_line,
  output logic tr_line
);
  // a released line floats to the pull-up level, never holds old value
  assign me_line = me_oe_n ? 1'h1 : me_out;
  assign te_line = te_oe_n ? 1'h1 : te_out;
  assign tr_line = tr_oe_n ? 1'h1 : tr_out;
endmodule : imb_partner

// ===== verif/trigger_flag_and_module_bus_control_bench.sv
`timescale 1ns/1ps
module trigger_flag_and_module_bus_control_bench;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, ovf, irq;
  logic trip_flag, err, me_o, me_oe_n, te_o, te_oe_n, tr_o, tr_oe_n;
  logic me_l, te_l, tr_l;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, e;
  int n_fail = 0;
  int checks = 0;
  localparam logic [31:0] one = 32'h0000_0001;
  localparam logic [31:0] s_set = one << trip_pkg::stb_set_bit;
  localparam logic [31:0] s_clr = one << trip_pkg::stb_clr_bit;
  localparam logic [31:0] s_clk = one << trip_pkg::stb_clk_bit;
  localparam logic [31:0] c_run = one << trip_pkg::ctl_run_bit;
  localparam logic [31:0] c_gate = one << trip_pkg::ctl_gate_en_bit;
  localparam logic [31:0] c_drv = one << trip_pkg::ctl_bus_drive_bit;
  localparam logic [11:0] stb = trip_pkg::strobe_off;
  localparam logic [11:0] ctl = trip_pkg::ctrl_off;

  trip_flag_ctrl trip_flag_ctrl_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overflow_pin(ovf), .bus_master_enable_line_in(me_l),
    .bus_master_enable_line_out(me_o),
    .bus_master_enable_line_oe_n(me_oe_n),
    .bus_trip_enable_line_in(te_l), .bus_trip_enable_line_out(te_o),
    .bus_trip_enable_line_oe_n(te_oe_n), .bus_trip_line_in(tr_l),
    .bus_trip_line_out(tr_o), .bus_trip_line_oe_n(tr_oe_n),
    .irq(irq), .trip_flag(trip_flag));

  imb_partner imb_partner_inst (.me_out(me_o), .me_oe_n(me_oe_n),
    .te_out(te_o), .te_oe_n(te_oe_n), .tr_out(tr_o), .tr_oe_n(tr_oe_n),
    .me_line(me_l), .te_line(te_l), .tr_line(tr_l));

  // ===========================================================
  // checking and apb tasks
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] got);
    checks++;
    if (got !== x) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, x, got);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // let strobe pulses and flag updates settle before the next access
    repeat (3) @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr

  task automatic rdv(input string nm, input logic [11:0] a,
                     input logic [31:0] x);
    xfer(1'h0, a, 32'h0000_0000);
    chk(nm, x, rd);
  endtask : rdv

  task automatic stat(input logic x);
    xfer(1'h0, trip_pkg::status_off, 32'h0000_0000);
    chk("trip", 32'(x), 32'(rd[trip_pkg::st_trip_bit]));
    chk("trip_flag", 32'(x), 32'(trip_flag));
  endtask : stat

  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // ===========================================================
  // clock and watchdog
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    test_done;
  end

  // ===========================================================
  // tests
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ovf = 1'h0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    rdv("ctrl", ctl, 32'(trip_pkg::ctrl_rst));
    chk("pslverr", 32'h0000_0000, 32'(err));
    chk("lines", 32'h0000_0007, {29'h0, tr_l, te_l, me_l});
    wr(stb, s_clr);
    stat(1'h0);
    wr(stb, s_set);
    stat(1'h1);
    wr(ctl, c_gate);
    wr(stb, s_clr);
    stat(1'h0);
    wr(stb, s_clk);
    stat(1'h1);
    wr(stb, s_set | s_clr | s_clk);
    stat(1'h0);
    // overflow rising without run must not trip the flag
    wr(ctl, 32'h0000_0000);
    // gated clock is refused while the gate is disabled
    wr(stb, s_clk);
    stat(1'h0);
    ovf <= 1'h1;
    repeat (8) @(posedge clk);
    stat(1'h0);
    chk("ovf", 32'h0000_0001, 32'(rd[trip_pkg::st_ovf_bit]));
    ovf <= 1'h0;
    wr(ctl, c_run);
    wr(stb, s_clr);
    stat(1'h0);
    ovf <= 1'h1;
    repeat (8) @(posedge clk);
    stat(1'h1);
    wr(stb, s_clr);
    stat(1'h0);
    ovf <= 1'h0;
    // interrupt: pending while masked, then raised and cleared by read
    wr(trip_pkg::irq_mask_off, 32'h0000_0000);
    xfer(1'h0, trip_pkg::irq_stat_off, 32'h0000_0000);
    wr(stb, s_set);
    chk("irq", 32'h0000_0000, 32'(irq));
    rdv("irq_stat", trip_pkg::irq_stat_off, 32'h0000_0001);
    rdv("irq_stat", trip_pkg::irq_stat_off, 32'h0000_0000);
    wr(trip_pkg::irq_mask_off, 32'h0000_0001);
    wr(stb, s_clr);
    wr(stb, s_set);
    chk("irq", 32'h0000_0001, 32'(irq));
    rdv("irq_stat", trip_pkg::irq_stat_off, 32'h0000_0001);
    chk("irq", 32'h0000_0000, 32'(irq));
    // each bus line driven high and low with the others released
    for (int i = 0; i < 3; i++) begin
      for (int v = 0; v < 2; v++) begin
        e = 32'h0000_0007;
        e[i] = v[0];
        wr(ctl, c_drv | (e << trip_pkg::ctl_me_bit));
        chk("lines", e, {29'h0, tr_l, te_l, me_l});
        repeat (4) @(posedge clk);
        rdv("status", trip_pkg::status_off, (e << 2) | one);
        chk("line_in", e, {29'h0, rd[4:2]});
      end
    end
    wr(ctl, c_drv);
    chk("lines", 32'h0000_0000, {29'h0, tr_l, te_l, me_l});
    wr(ctl, 32'h0000_0000);
    chk("lines", 32'h0000_0007, {29'h0, tr_l, te_l, me_l});
    // unmapped address is refused and leaves registers alone
    xfer(1'h1, 12'h014, 32'hffff_ffff);
    chk("pslverr", 32'h0000_0001, 32'(err));
    xfer(1'h0, 12'h014, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, 32'(err));
    chk("unmapped", 32'h0000_0000, rd);
    rdv("ctrl", ctl, 32'h0000_0000);
    // second reset in mid-run
    wr(ctl, c_drv);
    wr(stb, s_set);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    chk("trip_flag", 32'h0000_0000, 32'(trip_flag));
    chk("lines", 32'h0000_0007, {29'h0, tr_l, te_l, me_l});
    rst <= 1'h0;
    rdv("ctrl", ctl, 32'(trip_pkg::ctrl_rst));
    test_done;
  end
endmodule : trigger_flag_and_module_bus_control_bench
